//--- hdl/nvpot_serial.sv
`timescale 1ns/1ps
// ==========================================================
// Serial control of the stored wiper setting
// ==========================================================
// The host serial clock is sampled as a plain input; its rising edge is
// detected in the 20 MHz domain.
module nvpot_serial #(
  parameter int STORE_CYCLES = nvpot_pkg::STORE_CYC,
  parameter logic [7:0] NV_INIT = nvpot_pkg::NV_RESET_VALUE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic store_strobe,
  input wire logic supply_ok,
  output logic serial_out,
  output logic serial_out_en,
  output logic store_ready_n_busy,
  output logic [7:0] wiper_setting,
  output logic [7:0] nv_setting
);
  logic cs_f;
  logic sclk_q_r;
  logic sclk_rise;
  nvpot_pkg::nvpot_state_e state_r;
  nvpot_pkg::nvpot_state_e state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] wiper_r;
  logic [7:0] wiper_nxt;
  logic [7:0] nv_r;
  logic [7:0] nv_nxt;
  logic [7:0] store_strobe_r;
  logic [7:0] store_strobe_nxt;
  logic addr_hit_r;
  logic addr_hit_nxt;
  logic strobe_q_r;
  logic armed_r;
  logic armed_nxt;
  logic dout_r;
  logic dout_nxt;
  logic doe_r;
  logic doe_nxt;
  logic [31:0] busy_r;
  logic [31:0] busy_nxt;

  nvpot_cs_filter #(
    .FILT_CYC(nvpot_pkg::CS_FILTER_CYC)
  ) u_filter (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .cs_raw(chip_select),
    .cs_clean(cs_f)
  );

  assign sclk_rise = serial_clk & ~sclk_q_r; // see [R4]

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    wiper_nxt = wiper_r;
    nv_nxt = nv_r;
    store_strobe_nxt = store_strobe_r;
    addr_hit_nxt = addr_hit_r;
    armed_nxt = armed_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    busy_nxt = busy_r;
    // A rising strobe after the start bit arms a store. see [R7]
    if (store_strobe && !strobe_q_r && state_r != nvpot_pkg::NVPOT_IDLE) begin
      armed_nxt = 1'b1;
    end
    if (!cs_f && state_r != nvpot_pkg::NVPOT_STORE) begin
      // Select low acts as a reset back to the stored value. see [R1] [R2] [R16]
      state_nxt = nvpot_pkg::NVPOT_IDLE;
      wiper_nxt = nv_r;
      doe_nxt = 1'b0;
      dout_nxt = 1'b0;
      armed_nxt = 1'b0;
      cnt_nxt = 4'h0;
    end else begin
      case (state_r)
        nvpot_pkg::NVPOT_IDLE: begin
          doe_nxt = 1'b1; // see [R1]
          // Zeros before the start bit are idle. see [R22]
          if (sclk_rise && serial_in) begin
            state_nxt = nvpot_pkg::NVPOT_ADDR;
            cnt_nxt = 4'h0;
            addr_hit_nxt = 1'b0;
            shift_nxt = wiper_r;
          end
        end
        nvpot_pkg::NVPOT_ADDR: begin
          if (sclk_rise) begin
            if (cnt_r == 4'h0) begin
              addr_hit_nxt = (serial_in == nvpot_pkg::OWN_ADDR[0]);
              cnt_nxt = 4'h1;
            end else begin
              addr_hit_nxt = addr_hit_r & (serial_in == nvpot_pkg::OWN_ADDR[1]);
              cnt_nxt = 4'h0;
              state_nxt = nvpot_pkg::NVPOT_DATA;
              dout_nxt = shift_r[0]; // see [R10] [R15]
            end
          end
        end
        nvpot_pkg::NVPOT_DATA: begin
          if (sclk_rise) begin
            // Old contents leave LSB first as new bits enter. see [R10] [R15]
            shift_nxt = {serial_in, shift_r[7:1]};
            dout_nxt = shift_r[1];
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(nvpot_pkg::DATA_BITS - 1)) begin
              store_strobe_nxt = {serial_in, shift_r[7:1]};
              // Applied on the cycle after the last data bit. see [R12] [R17]
              if (addr_hit_r) begin
                wiper_nxt = {serial_in, shift_r[7:1]};
              end
              cnt_nxt = 4'h0;
              state_nxt = nvpot_pkg::NVPOT_GAP;
            end
          end
        end
        nvpot_pkg::NVPOT_GAP: begin
          if (sclk_rise) begin
            if (armed_r && addr_hit_r && cnt_r == 4'h0) begin
              busy_nxt = 32'h0;
              state_nxt = nvpot_pkg::NVPOT_STORE;
              doe_nxt = 1'b0; // see [R8]
            end else if (cnt_r == 4'(nvpot_pkg::GAP_CYC - 1)) begin
              // Ready for a new sequence; unstored data is dropped. see [R14] [R18]
              store_strobe_nxt = wiper_r;
              state_nxt = nvpot_pkg::NVPOT_IDLE;
              cnt_nxt = 4'h0;
            end else begin
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        nvpot_pkg::NVPOT_STORE: begin
          // Input is ignored and output is off while storing. see [R8]
          doe_nxt = 1'b0;
          armed_nxt = 1'b0;
          if (!supply_ok) begin
            state_nxt = nvpot_pkg::NVPOT_IDLE; // see [R9]
          end else if (busy_r >= 32'(STORE_CYCLES - 1)) begin
            nv_nxt = store_strobe_r;
            state_nxt = nvpot_pkg::NVPOT_IDLE;
          end else begin
            busy_nxt = busy_r + 32'h1;
          end
        end
        default: begin
          state_nxt = nvpot_pkg::NVPOT_IDLE;
        end
      endcase
    end
  end

  // Reset stands for power-up: the stored value loads with no serial clock. see [R6]
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= nvpot_pkg::NVPOT_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      wiper_r <= NV_INIT;
      nv_r <= NV_INIT;
      store_strobe_r <= NV_INIT;
      addr_hit_r <= 1'b0;
      strobe_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
      armed_r <= 1'b0;
      dout_r <= 1'b0;
      doe_r <= 1'b0;
      busy_r <= 32'h0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      wiper_r <= wiper_nxt;
      nv_r <= nv_nxt;
      store_strobe_r <= store_strobe_nxt;
      addr_hit_r <= addr_hit_nxt;
      strobe_q_r <= store_strobe;
      sclk_q_r <= serial_clk;
      armed_r <= armed_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign serial_out = dout_r & doe_r;
  assign serial_out_en = doe_r & cs_f; // see [R1]
  // Busy low only while a store with good supply runs. see [R7] [R9] [R22]
  assign store_ready_n_busy = ~((state_r == nvpot_pkg::NVPOT_STORE) & supply_ok);
  assign wiper_setting = wiper_r;
  assign nv_setting = nv_r;
endmodule

//--- shared/nvpot_pkg.sv
// Functional notes
// [R1] Transfers and output only while select high.
// [R2] Select low reloads stored value, output off.
// [R3] Filter select low glitches under 30-90 ns.
// [R4] Sample input, update output on clock rise.
// [R5] Host keeps clock running while storing.
// [R6] Power-up loads stored value without clocks.
// [R7] Store strobe drives ready low until done.
// [R8] While storing ignore input, output nothing.
// [R9] Low supply keeps ready high, store fails.
// [R10] Shift out LSB first after start, address.
// [R11] Host sends start, two address, eight data.
// [R12] New setting applies cycle after last bit.
// [R13] Host raises strobe 150 ns before edge.
// [R14] Ready for next sequence two cycles later.
// [R15] Every write shifts old contents out.
// [R16] Select low before clock 13 gives read-only.
// [R17] Temporary settings rewritable while selected.
// [R18] Without strobe, discard program data after two.
// [R19] Host reshifts value with strobe to store.
// [R20] Host sends one start bit, LSB first.
// [R21] Host leaves two cycles between sequences.
// [R22] Ready high idle; pre-start bits ignored.
package nvpot_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CS_FILTER_NS = 60;
  localparam int CS_FILTER_CYC = (CS_FILTER_NS * CLK_MHZ) / 1000;
  localparam int STORE_MS = 4;
  localparam int STORE_CYC = STORE_MS * CLK_MHZ * 1000;
  localparam int ADDR_BITS = 2;
  localparam int DATA_BITS = 8;
  localparam int GAP_CYC = 2;
  localparam logic [7:0] NV_RESET_VALUE = 8'h80;
  localparam logic [1:0] OWN_ADDR = 2'h1;
  typedef enum logic [4:0] {
    NVPOT_IDLE = 5'h01,
    NVPOT_ADDR = 5'h02,
    NVPOT_DATA = 5'h04,
    NVPOT_GAP = 5'h08,
    NVPOT_STORE = 5'h10
  } nvpot_state_e;
endpackage

//--- hdl/nvpot_cs_filter.sv
`timescale 1ns/1ps
// ==========================================================
// Select glitch filter
// ==========================================================
module nvpot_cs_filter #(
  parameter int FILT_CYC = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cs_raw,
  output logic cs_clean
);
  logic [7:0] low_cnt_r;
  logic [7:0] low_cnt_nxt;
  logic cs_r;
  logic cs_nxt;

  // A low must persist FILT_CYC + 1 samples before it is believed. see [R3]
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    cs_nxt = cs_r;
    if (cs_raw) begin
      low_cnt_nxt = 8'h00;
      cs_nxt = 1'b1;
    end else if (low_cnt_r >= FILT_CYC[7:0]) begin
      cs_nxt = 1'b0;
    end else begin
      low_cnt_nxt = low_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= 8'h00;
      cs_r <= 1'b0;
    end else if (clk_en) begin
      low_cnt_r <= low_cnt_nxt;
      cs_r <= cs_nxt;
    end
  end

  assign cs_clean = cs_r;
endmodule

//--- dv/nvpot_serial_properties.sv
`timescale 1ns/1ps
// ==================================================
// Port checker of the serial control block
// ==================================================
module nvpot_chk #(
  parameter int STORE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic supply_ok,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic store_ready_n_busy,
  input wire logic [7:0] wiper_setting,
  input wire logic [7:0] nv_setting
);
  logic [3:0] sclk_r;
  logic [31:0] busy_cnt_r;
  logic [4:0] hist;
  logic rise_recent;
  // The serial clock rise is detected and registered inside, so a rise counts for four cycles.
  assign hist = {sclk_r, serial_clk};
  assign rise_recent = |(hist[3:0] & ~hist[4:1]);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_r <= 4'h0;
      busy_cnt_r <= 32'h0;
    end else begin
      sclk_r <= hist[3:0];
      busy_cnt_r <= store_ready_n_busy ? 32'h0 : busy_cnt_r + 32'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_en_needs_select: assert property ($rose(serial_out_en) |-> chip_select)
    else $error("output enabled while unselected");
  a_unselected_reload: assert property (!chip_select [*5] |->
    !serial_out_en && wiper_setting == nv_setting)
    else $error("unselected state not restored");
  a_low_supply_ready: assert property (!supply_ok [*2] |-> store_ready_n_busy)
    else $error("busy shown with low supply");
  a_busy_bounded: assert property (busy_cnt_r <= STORE_CYCLES + 2)
    else $error("store busy too long");
  a_quiet_busy: assert property (!store_ready_n_busy && !$past(store_ready_n_busy) |->
    $stable(serial_out))
    else $error("output moved during store");
  a_nv_only_store: assert property (!$stable(nv_setting) |->
    !store_ready_n_busy || !$past(store_ready_n_busy))
    else $error("stored value changed outside store");
  a_out_on_sclk: assert property (!$stable(serial_out) && serial_out_en &&
    $past(serial_out_en) |-> rise_recent)
    else $error("output changed without serial clock");
  a_wiper_on_sclk: assert property (!$stable(wiper_setting) |->
    rise_recent || wiper_setting == nv_setting)
    else $error("wiper changed without serial clock");
  c_store: cover property ($fell(store_ready_n_busy));
  c_wiper: cover property (!$stable(wiper_setting) && chip_select);
  c_release: cover property ($fell(serial_out_en));
endmodule
bind nvpot_serial nvpot_chk #(.STORE_CYCLES(STORE_CYCLES)) nvpot_chk_inst (.clk, .reset,
  .chip_select, .serial_clk, .supply_ok, .serial_out, .serial_out_en, .store_ready_n_busy,
  .wiper_setting, .nv_setting);

//--- dv/nvpot_host.sv
`timescale 1ns/1ps
// ==================================================
// Host side of the three-wire link
// ==================================================
module nvpot_host (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic store_ready_n_busy,
  output logic chip_select,
  output logic serial_clk,
  output logic serial_in,
  output logic store_strobe
);
  initial begin
    chip_select = 1'b0;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    store_strobe = 1'b0;
  end
  // Seen is the output level just before this bit's rise.
  task automatic sbit(input logic b, output logic seen);
    @(posedge clk) serial_in <= b;
    repeat (2) @(posedge clk);
    seen = serial_out;
    serial_clk <= 1'b1;
    repeat (2) @(posedge clk);
    serial_clk <= 1'b0;
  endtask
  task automatic cs_low(input int n);
    @(posedge clk) chip_select <= 1'b0;
    repeat (n) @(posedge clk);
    chip_select <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] d, input logic st, input int n,
                       output logic [7:0] old, output logic busy);
    logic [10:0] w;
    logic seen;
    w = {d, 3'b011};
    busy = 1'b0;
    old = 8'h00;
    @(posedge clk) chip_select <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i == 1) store_strobe <= st;
      sbit(i < 11 ? w[i] : 1'b0, seen);
      if (i > 2 && i < 11) old[i - 3] = seen;
      busy |= !store_ready_n_busy;
    end
    for (int k = 0; k < 20 && !store_ready_n_busy; k++) sbit(1'b0, seen);
    store_strobe <= 1'b0;
    if (n < 13) cs_low(8);
  endtask
endmodule

//--- dv/nvpot_serial_tb.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin #1; cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
// ==================================================
// Testbench of the serial control block
// ==================================================
module nvpot_serial_tb;
  logic clk, reset, supply_ok, chip_select, serial_clk, serial_in, store_strobe;
  logic serial_out, serial_out_en, store_ready_n_busy, busy;
  logic [7:0] wiper_setting, nv_setting, old, exp_w, exp_nv;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] row_d [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
  logic row_st [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  nvpot_serial #(.STORE_CYCLES(20)) nvpot_serial_inst (.clk, .reset, .clk_en(1'b1),
    .chip_select, .serial_clk, .serial_in, .store_strobe, .supply_ok, .serial_out,
    .serial_out_en, .store_ready_n_busy, .wiper_setting, .nv_setting);
  nvpot_host nvpot_host_inst (.clk, .serial_out, .store_ready_n_busy, .chip_select,
    .serial_clk, .serial_in, .store_strobe);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    reset = 1'b1;
    supply_ok = 1'b1;
    exp_w = 8'h80;
    exp_nv = 8'h80;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("ready", store_ready_n_busy, 1'b1)
    `CHK("wiper", wiper_setting, exp_w)
    for (int i = 0; i < 4; i++) begin
      nvpot_host_inst.frame(row_d[i], row_st[i], 13, old, busy);
      `CHK("old", old, exp_w)
      `CHK("busy", busy, row_st[i])
      exp_w = row_d[i];
      if (row_st[i]) exp_nv = row_d[i];
      `CHK("wiper", wiper_setting, exp_w)
      `CHK("nv", nv_setting, exp_nv)
      `CHK("out_en_sel", serial_out_en, 1'b1)
    end
    nvpot_host_inst.cs_low(1);
    `CHK("glitch", wiper_setting, exp_w)
    nvpot_host_inst.cs_low(8);
    `CHK("reload", wiper_setting, exp_nv)
    nvpot_host_inst.frame(8'h00, 1'b0, 11, old, busy);
    `CHK("read", old, exp_nv)
    `CHK("kept", wiper_setting, exp_nv)
    supply_ok <= 1'b0;
    nvpot_host_inst.frame(8'h77, 1'b1, 13, old, busy);
    `CHK("low_supply", busy, 1'b0)
    nvpot_host_inst.cs_low(8);
    `CHK("nv_kept", nv_setting, exp_nv)
    report_and_stop();
  end
endmodule
